// ---- hw/ext_int_pkg.sv ----
// How it works
// - eleven sources are arbitrated, the five inherited ones arriving from outside plus six added ones, each with its own vector.
// - the added enable register answers at special-function address c8 and the added priority register at f8.
// - bits 7 and 6 of the added enable register are not stored, read as zero and steer nothing.
// - under processor control the transmit-error request at 4b is raised by missing acknowledge or collision when enable bit 5 is set.
// - under dma control the underrun flag also raises the transmit-error request.
// - the dma channel 1 request at 53 is raised by bit 1 of its control register when enable bit 4 is set.
// - under processor control the transmit-valid request at 43 is raised by transmit buffer not full when enable bit 3 is set.
// - under dma control the transmit-valid request is raised by the transmit finished flag instead.
// - the dma channel 0 request at 3b is raised by bit 1 of its control register when enable bit 2 is set.
// - in both modes the receive-error request at 33 is raised by check sequence, overrun, abort or alignment error when enable bit 1 is set.
// - under processor control the receive-valid request at 2b is raised by receive buffer not empty when enable bit 0 is set.
// - under dma control the receive-valid request is raised by the receive finished flag instead.
// - a source with priority bit 1 wins over a source with priority bit 0.
// - priority bits 5 to 0 belong to transmit error, dma 1, transmit valid, dma 0, receive error, receive valid.
// - within one level the order is ext0, rx valid, timer0, rx error, dma0, ext1, tx valid, dma1, timer1, tx error, serial port.
package ext_int_pkg;
	localparam logic [7:0] ADDED_INT_ENABLE_ADDR = 8'hc8;
	localparam logic [7:0] ADDED_INT_PRIORITY_ADDR = 8'hf8;
	localparam logic [7:0] ADDED_INT_ENABLE_RESET = 8'h00;
	localparam logic [7:0] ADDED_INT_PRIORITY_RESET = 8'h00;
	localparam logic [7:0] IMPL_MASK = 8'h3f;
	localparam int NUM_SOURCES = 11;
	// field positions in enable and priority registers
	localparam int RX_VALID_BIT = 0;
	localparam int RX_ERROR_BIT = 1;
	localparam int DMA0_BIT = 2;
	localparam int TX_VALID_BIT = 3;
	localparam int DMA1_BIT = 4;
	localparam int TX_ERROR_BIT = 5;
	localparam int DMA_DONE_BIT = 1;
	// tx_status_reg / rx_status_reg bit positions
	localparam int TX_FINISHED_POS = 3;
	localparam int TX_NOT_FULL_POS = 2;
	localparam int TX_COLLISION_POS = 4;
	localparam int TX_UNDERRUN_POS = 5;
	localparam int MISSING_ACK_POS = 6;
	localparam int RX_NOT_EMPTY_POS = 2;
	localparam int RX_FINISHED_POS = 3;
	localparam int CHECK_SEQ_POS = 4;
	localparam int ALIGN_ERR_POS = 5;
	localparam int RX_ABORT_POS = 6;
	localparam int RX_OVERRUN_POS = 7;
	// sources in same-level service order, index 0 first
	localparam logic [7:0] VECTOR_TABLE [NUM_SOURCES] = '{
		8'h03, 8'h2b, 8'h0b, 8'h33, 8'h3b, 8'h13, 8'h43, 8'h53, 8'h1b, 8'h4b, 8'h23};
endpackage

// ---- hw/int_arbiter.sv ----
`timescale 1ns/1ps
`default_nettype none
module int_arbiter
	import ext_int_pkg::*;
(
	input wire logic [NUM_SOURCES-1:0] req,
	input wire logic [NUM_SOURCES-1:0] high,
	output logic anyReq,
	output logic [3:0] winner,
	output logic winHigh
);
	logic [NUM_SOURCES-1:0] hiReq;
	logic [NUM_SOURCES-1:0] pick;
	assign hiReq = req & high;
	// high level pending masks all low ones
	assign pick = (|hiReq) ? hiReq : req;

	always_comb begin
		winner = 4'h0;
		for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
			if (pick[i]) begin
				winner = 4'(i);
			end
		end
	end
	assign anyReq = |req;
	assign winHigh = |hiReq;
endmodule // int_arbiter
`default_nettype wire

// ---- hw/extended_interrupt_sources.sv ----
`timescale 1ns/1ps
`default_nettype none
module extended_interrupt_sources
	import ext_int_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWdata,
	input wire logic sfrWe,
	input wire logic sfrRe,
	output logic [7:0] sfrRdata,
	output logic sfrHit,
	input wire logic serialDmaMode,
	input wire logic [7:0] tx_status_reg,
	input wire logic [7:0] rx_status_reg,
	input wire logic [7:0] dma_chan0_control,
	input wire logic [7:0] dma_chan1_control,
	input wire logic [4:0] baseReq,
	input wire logic [4:0] basePrio,
	output logic intReq,
	output logic [7:0] intVector,
	output logic intHighLevel
);
	logic [7:0] added_int_enable_r;
	logic [7:0] added_int_enable_nxt;
	logic [7:0] added_int_priority_r;
	logic [7:0] added_int_priority_nxt;
	logic [7:0] intVector_r;
	logic intReq_r;
	logic intHigh_r;
	wire enHit = sfrAddr == ADDED_INT_ENABLE_ADDR;
	wire prHit = sfrAddr == ADDED_INT_PRIORITY_ADDR;

	assign added_int_enable_nxt = (sfrWe && enHit) ? (sfrWdata & IMPL_MASK) :
		added_int_enable_r;
	assign added_int_priority_nxt = (sfrWe && prHit) ? (sfrWdata & IMPL_MASK) :
		added_int_priority_r;
	assign sfrHit = (sfrWe || sfrRe) && (enHit || prHit);
	// reads are combinational so the core sees data in the access cycle
	assign sfrRdata = !sfrRe ? 8'h00 : enHit ? added_int_enable_r :
		prHit ? added_int_priority_r : 8'h00;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			added_int_enable_r <= ADDED_INT_ENABLE_RESET;
			added_int_priority_r <= ADDED_INT_PRIORITY_RESET;
		end else begin
			added_int_enable_r <= added_int_enable_nxt;
			added_int_priority_r <= added_int_priority_nxt;
		end
	end

	// qualifying flag conditions per source
	wire txErrFlag = tx_status_reg[MISSING_ACK_POS] | tx_status_reg[TX_COLLISION_POS] |
		(serialDmaMode & tx_status_reg[TX_UNDERRUN_POS]);
	wire txValFlag = serialDmaMode ? tx_status_reg[TX_FINISHED_POS] :
		tx_status_reg[TX_NOT_FULL_POS];
	wire rxErrFlag = rx_status_reg[CHECK_SEQ_POS] | rx_status_reg[RX_OVERRUN_POS] |
		rx_status_reg[RX_ABORT_POS] | rx_status_reg[ALIGN_ERR_POS];
	wire rxValFlag = serialDmaMode ? rx_status_reg[RX_FINISHED_POS] :
		rx_status_reg[RX_NOT_EMPTY_POS];
	wire dma0Flag = dma_chan0_control[DMA_DONE_BIT];
	wire dma1Flag = dma_chan1_control[DMA_DONE_BIT];

	logic [5:0] addedFlags;
	logic [5:0] addedReq;
	assign addedFlags = {txErrFlag, dma1Flag, txValFlag, dma0Flag, rxErrFlag, rxValFlag};
	assign addedReq = addedFlags & added_int_enable_r[5:0];

	// base sources: 0 ext0, 1 timer0, 2 ext1, 3 timer1, 4 serial
	logic [NUM_SOURCES-1:0] allReq;
	logic [NUM_SOURCES-1:0] allHigh;
	assign allReq = {baseReq[4], addedReq[TX_ERROR_BIT], baseReq[3], addedReq[DMA1_BIT],
		addedReq[TX_VALID_BIT], baseReq[2], addedReq[DMA0_BIT], addedReq[RX_ERROR_BIT],
		baseReq[1], addedReq[RX_VALID_BIT], baseReq[0]};
	assign allHigh = {basePrio[4], added_int_priority_r[TX_ERROR_BIT], basePrio[3],
		added_int_priority_r[DMA1_BIT], added_int_priority_r[TX_VALID_BIT], basePrio[2],
		added_int_priority_r[DMA0_BIT], added_int_priority_r[RX_ERROR_BIT], basePrio[1],
		added_int_priority_r[RX_VALID_BIT], basePrio[0]};

	logic anyReq;
	logic [3:0] winner;
	logic winHigh;
	int_arbiter u_arb (
		.req(allReq),
		.high(allHigh),
		.anyReq(anyReq),
		.winner(winner),
		.winHigh(winHigh)
	);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			intReq_r <= 1'b0;
			intVector_r <= 8'h00;
			intHigh_r <= 1'b0;
		end else begin
			intReq_r <= anyReq;
			intVector_r <= anyReq ? VECTOR_TABLE[winner] : 8'h00;
			intHigh_r <= winHigh;
		end
	end
	assign intReq = intReq_r;
	assign intVector = intVector_r;
	assign intHighLevel = intHigh_r;
endmodule // extended_interrupt_sources
`default_nettype wire

// ---- verification/ext_int_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module ext_int_monitor(
	input wire logic sys_clk, resetn, sfrWe, sfrRe, sfrHit, serialDmaMode, intReq,
	input wire logic [7:0] sfrAddr, sfrWdata, sfrRdata, tx_status_reg, rx_status_reg,
	input wire logic [7:0] dma_chan0_control, intVector,
	input wire logic [4:0] baseReq, basePrio
);
	logic [5:0] enR;
	// enable shadow rebuilt from writes, so request checks see no hidden state
	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn) enR <= 6'h00;
		else if (sfrWe && sfrAddr == 8'hc8) enR <= sfrWdata[5:0];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_wr; sfrWe && sfrAddr == 8'hc8 ##1 sfrRe && sfrAddr == 8'hc8; endsequence
	property p_wr; s_wr |-> sfrRdata == ($past(sfrWdata) & 8'h3f); endproperty
	a_wr: assert property (p_wr) else $error("enable readback wrong");
	property p_hit; sfrHit == ((sfrWe || sfrRe) && (sfrAddr == 8'hc8 || sfrAddr == 8'hf8)); endproperty
	a_hit: assert property (p_hit) else $error("hit wrong");
	property p_unm; sfrRe && !sfrHit |-> sfrRdata == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_rv; !serialDmaMode && enR[0] && rx_status_reg[2] |=> intReq; endproperty
	a_rv: assert property (p_rv) else $error("rx valid request lost");
	property p_rd; serialDmaMode && enR[0] && rx_status_reg[3] |=> intReq; endproperty
	a_rd: assert property (p_rd) else $error("rx done request lost");
	property p_d0; enR[2] && dma_chan0_control[1] |=> intReq; endproperty
	a_d0: assert property (p_d0) else $error("dma0 request lost");
	property p_te; enR[5] && tx_status_reg[6] |=> intReq; endproperty
	a_te: assert property (p_te) else $error("tx error request lost");
	property p_x0; baseReq[0] && basePrio[0] |=> intVector == 8'h03; endproperty
	a_x0: assert property (p_x0) else $error("ext0 high did not win");
	property p_off; enR == 6'h00 && baseReq == 5'h00 |=> !intReq; endproperty
	a_off: assert property (p_off) else $error("request while nothing enabled");
endmodule // ext_int_monitor
bind extended_interrupt_sources ext_int_monitor u_mon(.sys_clk, .resetn, .sfrWe, .sfrRe, .sfrHit,
	.serialDmaMode, .intReq, .sfrAddr, .sfrWdata, .sfrRdata, .tx_status_reg, .rx_status_reg,
	.dma_chan0_control, .intVector, .baseReq, .basePrio);
`default_nettype wire

// ---- verification/core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// no acknowledge path: the core simply takes whatever vector stands
module core_model(
	input wire logic sys_clk, resetn, intReq,
	input wire logic [7:0] intVector,
	output logic [7:0] takenVec
);
	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn) takenVec <= 8'h00;
		else if (intReq) takenVec <= intVector;
endmodule // core_model
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb_top;
	typedef struct packed {logic m; logic [7:0] tx, rx; logic [1:0] d; logic [7:0] en, pr, vec; logic hi;} row_t;
	row_t rows [12] = '{
		'{0, 8'h00, 8'h04, 2'h0, 8'h01, 8'h00, 8'h2b, 0},
		'{1, 8'h00, 8'h08, 2'h0, 8'h01, 8'h00, 8'h2b, 0},
		'{1, 8'h00, 8'hf0, 2'h0, 8'h02, 8'h02, 8'h33, 1},
		'{0, 8'h00, 8'h00, 2'h1, 8'h04, 8'h00, 8'h3b, 0},
		'{0, 8'h04, 8'h00, 2'h0, 8'h08, 8'h00, 8'h43, 0},
		'{1, 8'h08, 8'h00, 2'h0, 8'h08, 8'h00, 8'h43, 0},
		'{0, 8'h00, 8'h00, 2'h2, 8'h10, 8'h10, 8'h53, 1},
		'{0, 8'h50, 8'h00, 2'h0, 8'h20, 8'h00, 8'h4b, 0},
		'{1, 8'h20, 8'h00, 2'h0, 8'h20, 8'h00, 8'h4b, 0},
		'{0, 8'h20, 8'h00, 2'h0, 8'h20, 8'h00, 8'h00, 0},
		'{1, 8'hff, 8'hff, 2'h3, 8'h3f, 8'h00, 8'h2b, 0},
		'{1, 8'hff, 8'hff, 2'h3, 8'h1f, 8'h30, 8'h53, 1}};
	logic sys_clk = 0, resetn = 0, sfrWe = 0, sfrRe = 0, serialDmaMode = 0, sfrHit, intReq, intHighLevel;
	logic [7:0] sfrAddr = 0, sfrWdata = 0, txS = 0, rxS = 0, d0 = 0, d1 = 0, sfrRdata, intVector, takenVec;
	logic [4:0] baseReq = 0, basePrio = 0;
	int fail_count = 0, n_compared = 0;
	always #50 sys_clk = ~sys_clk;
	extended_interrupt_sources u_dut(.sys_clk, .resetn, .sfrAddr, .sfrWdata, .sfrWe, .sfrRe,
		.sfrRdata, .sfrHit, .serialDmaMode, .tx_status_reg(txS), .rx_status_reg(rxS),
		.dma_chan0_control(d0), .dma_chan1_control(d1), .baseReq, .basePrio, .intReq,
		.intVector, .intHighLevel);
	core_model u_core(.sys_clk, .resetn, .intReq, .intVector, .takenVec);
	task automatic wr(input logic [7:0] a, v);
		@(negedge sys_clk);
		{sfrRe, sfrWe, sfrAddr, sfrWdata} = {2'b01, a, v};
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(negedge sys_clk);
		{sfrRe, sfrWe, sfrAddr} = {2'b10, a};
		@(posedge sys_clk);
		`CHK("sfrRdata", e, sfrRdata)
	endtask
	task automatic settle;
		@(negedge sys_clk);
		{sfrRe, sfrWe} = 2'b00;
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic tally_and_finish;
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge sys_clk);
		fail_count++;
		tally_and_finish;
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		resetn = 1;
		rd(8'hc8, 8'h00);
		rd(8'hf8, 8'h00);
		wr(8'hc8, 8'hff);
		rd(8'hc8, 8'h3f);
		rd(8'ha8, 8'h00);
		`CHK("sfrHit", 1'b0, sfrHit)
		$display("register test done");
		foreach (rows[i]) begin
			@(negedge sys_clk);
			{serialDmaMode, txS, rxS, d1[1], d0[1]} = {rows[i].m, rows[i].tx, rows[i].rx, rows[i].d};
			wr(8'hc8, rows[i].en);
			wr(8'hf8, rows[i].pr);
			settle;
			`CHK("int", {rows[i].vec != 0, rows[i].hi, rows[i].vec}, {intReq, intHighLevel, intVector})
			$display("row %0d done", i);
		end
		{serialDmaMode, txS, rxS, d0, d1, baseReq, basePrio} = {9'h000, 8'h04, 16'h0000, 10'h230};
		wr(8'hc8, 8'h01);
		wr(8'hf8, 8'h00);
		settle;
		`CHK("serial high", 10'h323, {intReq, intHighLevel, intVector})
		`CHK("core took", 8'h23, takenVec)
		basePrio = 5'h11;
		settle;
		`CHK("ext0 first", 10'h303, {intReq, intHighLevel, intVector})
		$display("inherited test done");
		resetn = 0;
		@(negedge sys_clk);
		`CHK("reset out", 9'h000, {intReq, intVector})
		{resetn, baseReq} = 6'h20;
		rd(8'hc8, 8'h00);
		settle;
		`CHK("no request", 1'b0, intReq)
		$display("second reset test done");
		tally_and_finish;
	end
endmodule // tb_top
`default_nettype wire
